// file: rtl/qenc_map.svh
// Register offsets, field positions, reset values and timing counts of the encoder input
`ifndef QENC_MAP_SVH
`define QENC_MAP_SVH
`define QENC_OFF_RES 12'h000
`define QENC_OFF_CFG 12'h004
`define QENC_OFF_STAT 12'h008
`define QENC_OFF_POS 12'h00c
`define QENC_OFF_SPEED 12'h010
`define QENC_CFG_DIR 0
`define QENC_CFG_CHK 1
`define QENC_CFG_TUNE 2
`define QENC_CFG_TC_LO 8
`define QENC_CFG_TC_HI 14
`define QENC_STAT_FAULT 0
`define QENC_STAT_SWAP 1
`define QENC_STAT_REV 2
`define QENC_RES_MIN 13'h0168
`define QENC_RES_MAX 13'h1000
`define QENC_RES_RST 13'h0400
`define QENC_TC_MAX 7'h64
`define QENC_TC_RST 7'h01
`define QENC_CLK_HZ 40000000
`define QENC_CYC_PER_MS (`QENC_CLK_HZ / 1000)
`define QENC_SPEED_WIN_MS 15
`define QENC_LOSS_MS 100
`define QENC_RPM_SCALE 32'h0000_03e8
`endif

// file: rtl/qenc_phase_filter.sv
// Glitch filter for one encoder phase: a new level must hold for the set time
module qenc_phase_filter (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_din,
    input wire qenc_pkg::hold_cyc_t i_hold_cyc,
    output logic o_dout
);
    import qenc_pkg::*;
    hold_cyc_t cnt_r;
    logic dout_r;
    wire logic same = (i_din == dout_r);
    wire logic done = (cnt_r >= i_hold_cyc);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            dout_r <= 1'b0;
        end else if (same) begin
            cnt_r <= '0;
        end else if (done) begin
            // Time constant reached: accept the new level
            dout_r <= i_din;
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 22'h000001;
        end
    end
    assign o_dout = dout_r;
endmodule

// file: rtl/qenc_pkg.sv
// Types shared by the encoder input design
package qenc_pkg;
    typedef enum logic [0:0] {
        DIV_IDLE = 1'b0,
        DIV_RUN = 1'b1
    } div_state_t;
    typedef logic [21:0] hold_cyc_t;
endpackage

// file: rtl/quadrature_encoder_input.sv
// Quadrature encoder input with APB registers: decode, count, speed, filter, faults
`include "qenc_map.svh"
module quadrature_encoder_input #(
    parameter int SPEED_WIN_CYC = `QENC_SPEED_WIN_MS * `QENC_CYC_PER_MS,
    parameter int LOSS_CYC = `QENC_LOSS_MS * `QENC_CYC_PER_MS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_enc_a,
    input wire logic i_enc_b,
    input wire logic i_motor_run,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_enc_fault,
    output logic o_phase_swap_warning,
    output logic o_reverse
);
    import qenc_pkg::*;

    function automatic logic [12:0] clamp(input logic [12:0] v, input logic [12:0] lo,
                                          input logic [12:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic [12:0] resolution_setting_code_r;
    logic direction_setting_code_r;
    logic fault_check_setting_code_r;
    logic tune_r;
    logic [6:0] input_filter_time_constant_r;
    logic fault_r, swap_r, rev_r;
    logic [31:0] pos_r, prdata_r, speed_r;
    logic pready_r, pslverr_r;
    logic [1:0] ab_r;
    logic [16:0] win_edges_r, tune_cnt_r;
    logic [31:0] win_cnt_r, loss_cnt_r;
    div_state_t div_st_r;
    logic [31:0] div_num_r, div_rem_r;
    logic [4:0] div_cnt_r;
    logic filt_a, filt_b;

    // Bus decode
    wire logic setup = i_psel & ~i_penable;
    wire logic wr = i_psel & i_penable & pready_r & i_pwrite;
    wire logic hit_res = (i_paddr == `QENC_OFF_RES);
    wire logic hit_cfg = (i_paddr == `QENC_OFF_CFG);
    wire logic hit_stat = (i_paddr == `QENC_OFF_STAT);
    wire logic hit_pos = (i_paddr == `QENC_OFF_POS);
    wire logic hit_spd = (i_paddr == `QENC_OFF_SPEED);
    wire logic mapped = hit_res | hit_cfg | hit_stat | hit_pos | hit_spd;
    wire logic [31:0] rd_mux =
        hit_res ? {19'h0, resolution_setting_code_r} :
        hit_cfg ? {17'h0, input_filter_time_constant_r, 5'h0, tune_r,
                   fault_check_setting_code_r, direction_setting_code_r} :
        hit_stat ? {29'h0, rev_r, swap_r, fault_r} :
        hit_pos ? pos_r :
        hit_spd ? speed_r : 32'h0;
    wire logic [12:0] tc_clamped = clamp({6'h0, i_pwdata[`QENC_CFG_TC_HI:`QENC_CFG_TC_LO]},
                                         13'h0000, {6'h0, `QENC_TC_MAX});
    wire logic [6:0] tc_wr = tc_clamped[6:0];
    wire logic [12:0] res_wr = clamp(i_pwdata[12:0], `QENC_RES_MIN, `QENC_RES_MAX);
    wire logic [1:0] clr_stat = (wr & hit_stat) ? i_pwdata[1:0] : 2'b00;
    wire logic cfg_wr = wr & hit_cfg;

    // Filter time constant in clock cycles, 1 ms step
    wire hold_cyc_t hold_cyc = hold_cyc_t'(input_filter_time_constant_r * `QENC_CYC_PER_MS);
    qenc_phase_filter filt_a_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_din(i_enc_a), .i_hold_cyc(hold_cyc),
        .o_dout(filt_a)
    );
    qenc_phase_filter filt_b_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_din(i_enc_b), .i_hold_cyc(hold_cyc),
        .o_dout(filt_b)
    );

    // Quadrature decode on filtered phases, {A,B}
    wire logic [1:0] ab = {filt_a, filt_b};
    wire logic a_lead = (ab == {~ab_r[0], ab_r[1]});
    wire logic b_lead = (ab == {ab_r[0], ~ab_r[1]});
    wire logic illegal = ((ab ^ ab_r) == 2'b11);
    wire logic fwd = direction_setting_code_r ? b_lead : a_lead;
    wire logic rev = direction_setting_code_r ? a_lead : b_lead;
    wire logic [16:0] step = fwd ? 17'h00001 : (rev ? 17'h1ffff : 17'h00000);
    wire logic [16:0] win_next = win_edges_r + step;
    wire logic win_end = (win_cnt_r == 32'(SPEED_WIN_CYC - 1));
    wire logic loss_hit = (loss_cnt_r == 32'(LOSS_CYC - 1));
    // Open-collector encoders cannot be checked; software clears the enable
    wire logic chk = fault_check_setting_code_r;
    wire logic fault_set = chk & (illegal | (loss_hit & i_motor_run));
    // Tuning drives the motor forward; a net reverse count means swapped wiring
    wire logic swap_set = tune_r & cfg_wr & ~i_pwdata[`QENC_CFG_TUNE] & tune_cnt_r[16];
    wire logic [16:0] win_mag = win_edges_r[16] ? (17'h0 - win_edges_r) : win_edges_r;
    wire logic [32:0] div_try = {div_rem_r, div_num_r[31]} - {20'h0, resolution_setting_code_r};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            resolution_setting_code_r <= `QENC_RES_RST;
            direction_setting_code_r <= 1'b0;
            fault_check_setting_code_r <= 1'b1;
            tune_r <= 1'b0;
            input_filter_time_constant_r <= `QENC_TC_RST;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r <= setup ? rd_mux : prdata_r;
            if (wr & hit_res) begin
                resolution_setting_code_r <= res_wr;
            end
            if (cfg_wr) begin
                direction_setting_code_r <= i_pwdata[`QENC_CFG_DIR];
                fault_check_setting_code_r <= i_pwdata[`QENC_CFG_CHK];
                tune_r <= i_pwdata[`QENC_CFG_TUNE];
                input_filter_time_constant_r <= tc_wr;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ab_r <= 2'b00;
            pos_r <= 32'h0;
            rev_r <= 1'b0;
            fault_r <= 1'b0;
            swap_r <= 1'b0;
            tune_cnt_r <= 17'h0;
            loss_cnt_r <= 32'h0;
        end else begin
            ab_r <= ab;
            pos_r <= pos_r + {{15{step[16]}}, step};
            rev_r <= rev ? 1'b1 : (fwd ? 1'b0 : rev_r);
            // Set wins over a clear in the same cycle
            fault_r <= (fault_r & ~clr_stat[0]) | fault_set;
            swap_r <= (swap_r & ~clr_stat[1]) | swap_set;
            tune_cnt_r <= tune_r ? tune_cnt_r + step : 17'h0;
            loss_cnt_r <= (fwd | rev | ~i_motor_run | loss_hit) ? 32'h0 : loss_cnt_r + 32'h1;
        end
    end

    // Speed in rpm: edges per 15 ms times 1000 over pulses per turn
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            win_cnt_r <= 32'h0;
            win_edges_r <= 17'h0;
            div_st_r <= DIV_IDLE;
            div_num_r <= 32'h0;
            div_rem_r <= 32'h0;
            div_cnt_r <= 5'h0;
            speed_r <= 32'h0;
        end else begin
            win_cnt_r <= win_end ? 32'h0 : win_cnt_r + 32'h1;
            win_edges_r <= win_end ? 17'h0 : win_next;
            case (div_st_r)
                DIV_IDLE: begin
                    if (win_end) begin
                        div_num_r <= {15'h0, win_mag} * `QENC_RPM_SCALE;
                        div_rem_r <= 32'h0;
                        div_cnt_r <= 5'h0;
                        div_st_r <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    div_rem_r <= div_try[32] ? {div_rem_r[30:0], div_num_r[31]} : div_try[31:0];
                    div_num_r <= {div_num_r[30:0], ~div_try[32]};
                    div_cnt_r <= div_cnt_r + 5'h1;
                    if (div_cnt_r == 5'h1f) begin
                        speed_r <= {div_num_r[30:0], ~div_try[32]};
                        div_st_r <= DIV_IDLE;
                    end
                end
                default: div_st_r <= DIV_IDLE;
            endcase
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_enc_fault = fault_r;
    assign o_phase_swap_warning = swap_r;
    assign o_reverse = rev_r;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    res_range_a: assert property (
        resolution_setting_code_r >= 13'h0168 && resolution_setting_code_r <= 13'h1000)
        else $error("resolution outside 360..4096");
    fwd_order_a: assert property (
        !direction_setting_code_r && a_lead |=> pos_r == $past(pos_r) + 32'h1)
        else $error("A lead did not count forward");
    alt_order_a: assert property (
        direction_setting_code_r && a_lead |=> pos_r == $past(pos_r) - 32'h1)
        else $error("A lead did not count reverse in B lead mode");
    miswire_fault_a: assert property (
        chk && illegal |=> o_enc_fault)
        else $error("illegal transition missed");
    swap_warn_a: assert property (
        tune_r && cfg_wr && !i_pwdata[2] && tune_cnt_r[16] |=> o_phase_swap_warning)
        else $error("swap warning not raised");
    filter_max_a: assert property (
        input_filter_time_constant_r <= 7'h64)
        else $error("filter constant above 100 ms");
    loss_fault_a: assert property (
        chk && loss_hit && i_motor_run |=> o_enc_fault)
        else $error("pulse loss not flagged");
    pos_hold_a: assert property (
        !fwd && !rev |=> $stable(pos_r))
        else $error("position moved without transition");
    apb_ready_a: assert property (
        i_psel && !i_penable |=> o_pready)
        else $error("pready not one cycle after setup");
    // Back-to-back setups are legal, so only the access edge ends the pulse
    apb_drop_a: assert property (
        i_psel && i_penable |=> !o_pready)
        else $error("pready held past the access cycle");
endmodule

// file: tb/qenc_shaft_model.sv
// Shaft encoder model: push-pull two-phase quadrature source
module qenc_shaft_model (
    input wire logic i_clk,
    output logic o_enc_a,
    output logic o_enc_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Push-pull outputs, so fault checking may stay on
    logic [1:0] ph_r = 2'b00;
    assign o_enc_a = ph_r[1];
    assign o_enc_b = ph_r[0];
    // A lead walks {A,B} 00,10,11,01; one phase moves per step
    task automatic turn(input bit a_lead, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(posedge i_clk);
            ph_r <= a_lead ? {~ph_r[0], ph_r[1]} : {ph_r[0], ~ph_r[1]};
        end
    endtask
    // Both phases at once, as a miswired or broken cable shows
    task automatic jump();
        @(posedge i_clk);
        ph_r <= ~ph_r;
    endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the quadrature encoder input
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic i_motor_run = 1'b0;
    logic enc_a, enc_b, pready, slverr, fault, swap, rev, err;
    logic [31:0] prdata, rd;
    int n_errors = 0;
    int total_checks = 0;
    always #12.5 i_clk = ~i_clk;
    // Short windows keep the run brief
    quadrature_encoder_input #(.SPEED_WIN_CYC(400), .LOSS_CYC(300)) i_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_enc_a(enc_a), .i_enc_b(enc_b), .i_motor_run(i_motor_run),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr),
        .o_enc_fault(fault), .o_phase_swap_warning(swap), .o_reverse(rev));
    qenc_shaft_model i_enc (.i_clk(i_clk), .o_enc_a(enc_a), .o_enc_b(enc_b));
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        t = 0;
        do begin
            @(posedge i_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t == 50) n_errors++;
        rd = prdata;
        err = slverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(nm, e, rd);
    endtask
    task automatic step(input bit al, input int n);
        i_enc.turn(al, n, 8);
        repeat (4) @(posedge i_clk);
    endtask
    task automatic t_regs();
        rdc("res", 12'h000, 32'h0000_0400);
        rdc("cfg", 12'h004, 32'h0000_0102);
        apb(1'b0, 12'h014, 32'h0);
        check("slverr", 32'h1, {31'h0, err});
        apb(1'b1, 12'h000, 32'd100);
        rdc("res low", 12'h000, 32'h0000_0168);
        apb(1'b1, 12'h000, 32'd5000);
        rdc("res high", 12'h000, 32'h0000_1000);
        apb(1'b1, 12'h004, 32'h0000_7f02);
        rdc("tc max", 12'h004, 32'h0000_6402);
        // Eight-cycle pulse on phase A is far below the filter time
        i_enc.turn(1'b1, 1, 8);
        i_enc.turn(1'b0, 1, 8);
        repeat (4) @(posedge i_clk);
        rdc("glitch", 12'h00c, 32'h0);
        apb(1'b1, 12'h004, 32'h0000_0002);
        $display("register test done");
    endtask
    task automatic t_dir();
        step(1'b1, 8);
        rdc("pos a fwd", 12'h00c, 32'd8);
        step(1'b0, 4);
        rdc("pos b rev", 12'h00c, 32'd4);
        check("rev", 32'h1, {31'h0, rev});
        apb(1'b1, 12'h004, 32'h0000_0003);
        step(1'b1, 8);
        rdc("pos a rev", 12'h00c, 32'hffff_fffc);
        step(1'b0, 10);
        rdc("pos b fwd", 12'h00c, 32'd6);
        check("fwd", 32'h0, {31'h0, rev});
        apb(1'b1, 12'h004, 32'h0000_0002);
        $display("direction test done");
    endtask
    task automatic t_fault();
        i_enc.jump();
        repeat (6) @(posedge i_clk);
        check("fault", 32'h1, {31'h0, fault});
        rdc("stat", 12'h008, 32'h1);
        rdc("pos kept", 12'h00c, 32'd6);
        apb(1'b1, 12'h008, 32'h1);
        rdc("stat clr", 12'h008, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        i_enc.jump();
        repeat (6) @(posedge i_clk);
        check("fault off", 32'h0, {31'h0, fault});
        apb(1'b1, 12'h004, 32'h0000_0002);
        i_motor_run <= 1'b1;
        step(1'b1, 40);
        check("no loss", 32'h0, {31'h0, fault});
        repeat (320) @(posedge i_clk);
        check("loss", 32'h1, {31'h0, fault});
        i_motor_run <= 1'b0;
        apb(1'b1, 12'h008, 32'h1);
        $display("fault test done");
    endtask
    task automatic t_swap();
        apb(1'b1, 12'h004, 32'h0000_0006);
        step(1'b1, 8);
        apb(1'b1, 12'h004, 32'h0000_0002);
        repeat (2) @(posedge i_clk);
        check("no swap", 32'h0, {31'h0, swap});
        apb(1'b1, 12'h004, 32'h0000_0006);
        step(1'b0, 8);
        apb(1'b1, 12'h004, 32'h0000_0002);
        repeat (2) @(posedge i_clk);
        check("swap", 32'h1, {31'h0, swap});
        rdc("stat swap", 12'h008, 32'h6);
        $display("swap test done");
    endtask
    task automatic t_speed();
        apb(1'b1, 12'h000, 32'd1000);
        fork
            i_enc.turn(1'b1, 120, 10);
            begin
                repeat (1000) @(posedge i_clk);
                apb(1'b0, 12'h010, 32'h0);
            end
        join
        total_checks++;
        // One edge of slack for window alignment; 40 edges per window
        if (rd !== 32'd39 && rd !== 32'd40 && rd !== 32'd41) begin
            n_errors++;
            $display("wrong value speed expected 40 seen %h", rd);
        end
        $display("speed test done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_dir();
        t_fault();
        t_swap();
        t_speed();
        results();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        results();
    end
endmodule
